// File: rsc_consts.vh
// Register offsets, field positions, reset values and timing counts for the reset source block
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RSC_OFS_BROWNOUT_CTRL 8'h00
`define RSC_OFS_APP_INT_RESET 8'h04
`define RSC_OFS_PERIPH_RST0 8'h08
`define RSC_OFS_PERIPH_RST1 8'h0C
`define RSC_OFS_PERIPH_RST2 8'h10
`define RSC_OFS_WDOG_LOAD 8'h14
`define RSC_OFS_WDOG_CTRL 8'h18
`define RSC_OFS_WDOG_CLEAR 8'h1C
`define RSC_OFS_WDOG_VALUE 8'h20
`define RSC_OFS_MAIN_OSC_CTRL 8'h24
`define RSC_OFS_RESET_CAUSE 8'h28
`define RSC_OFS_INT_CTRL_STATE 8'h2C
`define RSC_OFS_STATUS 8'h30

// ****************************************************************
// Field positions
// ****************************************************************
`define RSC_BIT_BROWNOUT_RESET_SELECT 1
`define RSC_BIT_CORE_ONLY_RESET 0
`define RSC_BIT_SYSTEM_RESET_REQUEST 2
`define RSC_BIT_WDOG_INT_EN 0
`define RSC_BIT_WDOG_RESET_EN 1
`define RSC_BIT_OSC_CHECK_ENABLE 0
`define RSC_BIT_SW_URGENT_SET 31
`define RSC_BIT_CAUSE_EXT 0
`define RSC_BIT_CAUSE_POR 1
`define RSC_BIT_CAUSE_BOR 2
`define RSC_BIT_CAUSE_WDOG 3
`define RSC_BIT_CAUSE_SW 4
`define RSC_BIT_CAUSE_OSC_FAIL 16

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RSC_RST_BROWNOUT_CTRL 32'h0000_0000
`define RSC_RST_WDOG_LOAD 32'hFFFF_FFFF
`define RSC_BOR_HOLD_US 500
`define RSC_CLK_MHZ 100
`define RSC_BOR_HOLD_CYCLES (`RSC_BOR_HOLD_US * `RSC_CLK_MHZ)
`define RSC_RESET_PULSE_CYCLES 16

`endif

// File: rsc_reset_source_control.v
// Reset and urgent-interrupt source control with AXI4-Lite register access
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "rsc_consts.vh"

module rsc_reset_source_control #(
    parameter PERIPH_W = 32,
    parameter BOR_HOLD = `RSC_BOR_HOLD_CYCLES,
    parameter PULSE = `RSC_RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // AXI4-Lite write address, data and response
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog and external event inputs
    input wire brownout_detect,
    input wire flash_busy,
    input wire ext_reset_n,
    input wire urgent_interrupt,
    input wire urgent_pin_enable,
    input wire osc_fault,
    input wire osc_wdog_tick,
    // Reset and interrupt outputs
    output reg system_reset,
    output reg core_reset,
    output reg boot_fetch_start,
    output reg [3*PERIPH_W-1:0] periph_reset,
    output reg brownout_irq,
    output reg wdog_irq,
    output reg urgent_irq
);

    // ****************************************************************
    // Reset synchroniser and input conditioning
    // ****************************************************************
    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];

    // Release reset through two flops so deassertion is clean
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // Three-flop pin filters; a level counts once stages two and three agree
    wire [4:0] pin_raw = {osc_wdog_tick, ext_reset_n, osc_fault,
        urgent_interrupt & urgent_pin_enable, brownout_detect};
    reg [4:0] st1, st2, st3, filt;
    reg tick_q;
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st1 <= 5'h08;
            st2 <= 5'h08;
            st3 <= 5'h08;
            filt <= 5'h08;
            tick_q <= 1'b0;
        end
        else
        begin
            st1 <= pin_raw;
            st2 <= st1;
            st3 <= st2;
            filt <= (st2 & st3) | (filt & (st2 | st3)); // Old level kept on disagreement
            tick_q <= filt[4];
        end
    end
    wire bod_f = filt[0];
    wire pin_f = filt[1];
    wire osc_f = filt[2];
    wire ext_f = filt[3];
    wire tick_f = filt[4];
    wire osc_tick_en = tick_f & ~tick_q; // One enable per rising oscillator edge

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg bor_select, osc_check_en, sw_urgent, core_req, sys_req;
    reg [3*PERIPH_W-1:0] periph_ctrl;
    reg [31:0] wd_load [0:1];
    reg [1:0] wd_int_en, wd_rst_en, wd_int_flag;
    reg [31:0] wd_count [0:1];
    reg [31:0] cause;
    reg bor_cond, bor_irq_flag, osc_fail_pend;
    localparam BT_W = $clog2(BOR_HOLD + 1);
    localparam [31:0] BOR_HOLD_32 = BOR_HOLD;
    localparam [31:0] PULSE_32 = PULSE;
    reg [BT_W-1:0] bor_timer;
    integer k;

    // Write channel: take address and data in either order
    reg aw_held, w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire aw_ok = aw_held | (s_axi_awvalid & s_axi_awready);
    wire w_ok = w_held | (s_axi_wvalid & s_axi_wready);
    wire do_write = aw_ok & w_ok & ~s_axi_bvalid;
    wire wr_full = (s_axi_wstrb == 4'hF);
    wire [1:0] wd_clear = (do_write && wr_full && wr_addr == `RSC_OFS_WDOG_CLEAR) ?
        wr_data[1:0] : 2'b00;
    wire bor_event = bod_f & ~bor_cond;

    // ****************************************************************
    // Reset generation state
    // ****************************************************************
    reg [7:0] pulse_cnt;
    wire [1:0] wd_step = {osc_tick_en, 1'b1}; // Instance one counts oscillator edges
    wire [1:0] wd_zero = {wd_count[1] == 32'h0000_0000, wd_count[0] == 32'h0000_0000};
    wire wd_fire0 = wd_rst_en[0] & wd_int_flag[0] & wd_zero[0];
    wire wd_fire1 = wd_rst_en[1] & wd_int_flag[1] & wd_zero[1] & osc_tick_en;
    wire bor_reset = bor_event & (bor_select | flash_busy);
    wire osc_fail = osc_check_en & osc_f;
    wire any_sys = bor_reset | sys_req | wd_fire0 | wd_fire1 | osc_fail | ~ext_f;

    // Register writes, watchdogs, cause capture and reset requests
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            bor_select <= 1'b0;
            osc_check_en <= 1'b0;
            sw_urgent <= 1'b0;
            core_req <= 1'b0;
            sys_req <= 1'b0;
            periph_ctrl <= {3*PERIPH_W{1'b0}};
            wd_load[0] <= `RSC_RST_WDOG_LOAD;
            wd_load[1] <= `RSC_RST_WDOG_LOAD;
            wd_count[0] <= `RSC_RST_WDOG_LOAD;
            wd_count[1] <= `RSC_RST_WDOG_LOAD;
            wd_int_en <= 2'b00;
            wd_rst_en <= 2'b00;
            wd_int_flag <= 2'b00;
            cause <= 32'h0000_0002;
            bor_cond <= 1'b0;
            bor_irq_flag <= 1'b0;
            bor_timer <= {BT_W{1'b0}};
            osc_fail_pend <= 1'b0;
        end
        else
        begin
            // Handshake bookkeeping
            if (s_axi_awvalid & s_axi_awready & ~do_write)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_write)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            core_req <= 1'b0;
            sys_req <= 1'b0;
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                // Partial-lane writes are refused rather than merged
                if (!wr_full)
                    s_axi_bresp <= 2'b10;
                else
                    case (wr_addr)
                    `RSC_OFS_BROWNOUT_CTRL:
                        bor_select <= wr_data[`RSC_BIT_BROWNOUT_RESET_SELECT];
                    `RSC_OFS_APP_INT_RESET:
                    begin
                        sys_req <= wr_data[`RSC_BIT_SYSTEM_RESET_REQUEST];
                        core_req <= wr_data[`RSC_BIT_CORE_ONLY_RESET];
                    end
                    `RSC_OFS_PERIPH_RST0: periph_ctrl[PERIPH_W-1:0] <= wr_data[PERIPH_W-1:0];
                    `RSC_OFS_PERIPH_RST1:
                        periph_ctrl[2*PERIPH_W-1:PERIPH_W] <= wr_data[PERIPH_W-1:0];
                    `RSC_OFS_PERIPH_RST2:
                        periph_ctrl[3*PERIPH_W-1:2*PERIPH_W] <= wr_data[PERIPH_W-1:0];
                    `RSC_OFS_WDOG_LOAD:
                    begin
                        wd_load[wr_data[31]] <= {1'b0, wr_data[30:0]};
                    end
                    `RSC_OFS_WDOG_CTRL:
                    begin
                        wd_int_en <= {wr_data[8 + `RSC_BIT_WDOG_INT_EN], wr_data[`RSC_BIT_WDOG_INT_EN]};
                        wd_rst_en <= {wr_data[8 + `RSC_BIT_WDOG_RESET_EN],
                            wr_data[`RSC_BIT_WDOG_RESET_EN]};
                    end
                    `RSC_OFS_WDOG_CLEAR: ; // Acted on through wd_clear
                    `RSC_OFS_MAIN_OSC_CTRL: osc_check_en <= wr_data[`RSC_BIT_OSC_CHECK_ENABLE];
                    `RSC_OFS_RESET_CAUSE: cause <= wr_data & cause;
                    `RSC_OFS_INT_CTRL_STATE:
                        if (wr_data[`RSC_BIT_SW_URGENT_SET]) sw_urgent <= 1'b1;
                    `RSC_OFS_STATUS:
                        if (wr_data[0]) bor_irq_flag <= 1'b0;
                    default: s_axi_bresp <= 2'b10;
                    endcase
            end
            // Brown-out condition and its 500 us self-clear
            if (bor_event)
            begin
                bor_cond <= 1'b1;
                bor_timer <= BOR_HOLD_32[BT_W-1:0];
                if (!(bor_select | flash_busy)) bor_irq_flag <= 1'b1;
            end
            else if (bor_cond && !bod_f)
            begin
                if (bor_timer == 0)
                    bor_cond <= 1'b0;
                else
                    bor_timer <= bor_timer - 1'b1;
            end
            // Watchdogs: flag and reload on first zero, reset on second
            // A clear loses to a timeout landing in the same cycle
            for (k = 0; k < 2; k = k + 1)
            begin
                if (wd_int_en[k] & wd_step[k])
                begin
                    if (wd_zero[k])
                    begin
                        wd_count[k] <= wd_load[k];
                        wd_int_flag[k] <= 1'b1;
                    end
                    else
                        wd_count[k] <= wd_count[k] - 32'h0000_0001;
                end
                if (wd_clear[k] && !(wd_int_en[k] && wd_step[k] && wd_zero[k]))
                begin
                    wd_int_flag[k] <= 1'b0;
                    wd_count[k] <= wd_load[k];
                end
            end
            // Cause recording; external clears the rest, others are sticky
            if (!ext_f)
                cause <= 32'h0000_0001;
            else
            begin
                if (bor_reset) cause[`RSC_BIT_CAUSE_BOR] <= 1'b1;
                if (wd_fire0 | wd_fire1) cause[`RSC_BIT_CAUSE_WDOG] <= 1'b1;
                if (sys_req) cause[`RSC_BIT_CAUSE_SW] <= 1'b1;
                if (osc_fail)
                begin
                    cause[`RSC_BIT_CAUSE_OSC_FAIL] <= 1'b1;
                    osc_fail_pend <= 1'b1;
                    osc_check_en <= 1'b0;
                end
            end
            if (boot_fetch_start & osc_fail_pend)
                osc_fail_pend <= 1'b0;
            // A system reset request in any_sys clears the watchdog interrupt enables and flags and the peripheral reset controls
            if (any_sys)
            begin
                wd_int_en <= 2'b00;
                wd_int_flag <= 2'b00;
                periph_ctrl <= {3*PERIPH_W{1'b0}};
            end
        end
    end

    // ****************************************************************
    // Reset pulse, boot fetch and interrupt outputs
    // ****************************************************************
    // Hold while external reset, or a brown-out with bor_select or flash_busy set, persists, then a fixed tail
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pulse_cnt <= PULSE_32[7:0];
            system_reset <= 1'b1;
            core_reset <= 1'b1;
            boot_fetch_start <= 1'b0;
            periph_reset <= {3*PERIPH_W{1'b0}};
            brownout_irq <= 1'b0;
            wdog_irq <= 1'b0;
            urgent_irq <= 1'b0;
        end
        else
        begin
            boot_fetch_start <= 1'b0;
            if (any_sys | (bor_cond & bod_f & (bor_select | flash_busy)))
            begin
                pulse_cnt <= PULSE_32[7:0];
                system_reset <= 1'b1;
                core_reset <= 1'b1;
            end
            else if (core_req & (pulse_cnt == 8'h00))
            begin
                pulse_cnt <= PULSE_32[7:0];
                core_reset <= 1'b1;
            end
            else if (pulse_cnt != 8'h00)
                pulse_cnt <= pulse_cnt - 8'h01;
            else if (core_reset)
            begin
                system_reset <= 1'b0;
                core_reset <= 1'b0;
                boot_fetch_start <= 1'b1;
            end
            periph_reset <= periph_ctrl;
            brownout_irq <= bor_irq_flag;
            wdog_irq <= |(wd_int_flag & wd_int_en);
            urgent_irq <= pin_f | sw_urgent | (osc_fail_pend & ~core_reset);
        end
    end

    // Read channel
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
            `RSC_OFS_BROWNOUT_CTRL:
                s_axi_rdata <= {30'h0, bor_select, 1'b0};
            `RSC_OFS_APP_INT_RESET: s_axi_rdata <= 32'h0000_0000;
            `RSC_OFS_PERIPH_RST0: s_axi_rdata <= periph_ctrl[PERIPH_W-1:0];
            `RSC_OFS_PERIPH_RST1: s_axi_rdata <= periph_ctrl[2*PERIPH_W-1:PERIPH_W];
            `RSC_OFS_PERIPH_RST2: s_axi_rdata <= periph_ctrl[3*PERIPH_W-1:2*PERIPH_W];
            `RSC_OFS_WDOG_LOAD: s_axi_rdata <= wd_load[0];
            `RSC_OFS_WDOG_CTRL:
                s_axi_rdata <= {22'h0, wd_rst_en[1], wd_int_en[1], 6'h00,
                    wd_rst_en[0], wd_int_en[0]};
            `RSC_OFS_WDOG_CLEAR: s_axi_rdata <= {30'h0, wd_int_flag};
            `RSC_OFS_WDOG_VALUE: s_axi_rdata <= wd_count[0];
            `RSC_OFS_MAIN_OSC_CTRL: s_axi_rdata <= {31'h0, osc_check_en};
            `RSC_OFS_RESET_CAUSE: s_axi_rdata <= cause;
            `RSC_OFS_INT_CTRL_STATE: s_axi_rdata <= {sw_urgent, 31'h0};
            `RSC_OFS_STATUS:
                s_axi_rdata <= {28'h0, osc_fail_pend, pin_f, bor_cond, bor_irq_flag};
            default:
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end
            endcase
        end
    end

endmodule // rsc_reset_source_control

// File: rsc_reset_source_control_checker.sv
// Concurrent checks on the reset source control block ports
module rsc_reset_source_control_checker #(
    parameter PERIPH_W = 32
) (
    input wire clock,
    input wire rstn,
    input wire s_axi_bvalid,
    input wire brownout_detect,
    input wire flash_busy,
    input wire urgent_interrupt,
    input wire urgent_pin_enable,
    input wire system_reset,
    input wire core_reset,
    input wire boot_fetch_start,
    input wire [3*PERIPH_W-1:0] periph_reset,
    input wire brownout_irq,
    input wire wdog_irq,
    input wire urgent_irq
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // Tail after power-on must end in a boot fetch
    property p_boot_after_por;
        $rose(rstn) |-> ##[16:24] boot_fetch_start;
    endproperty
    // Fetch pulse comes with the core leaving reset
    property p_boot_core_free;
        boot_fetch_start |-> ##[0:1] !core_reset;
    endproperty
    property p_core_drop_fetch;
        $fell(core_reset) |-> boot_fetch_start || $past(boot_fetch_start);
    endproperty
    // Filter delay allowed before the forced reset
    property p_flash_bor;
        (flash_busy && brownout_detect)[*6] |-> ##[0:4] system_reset;
    endproperty
    // Core-only reset leaves peripheral resets alone
    property p_core_only;
        core_reset && !system_reset |-> $stable(periph_reset);
    endproperty
    // Peripheral resets move only by a bus write or a system reset
    property p_periph_src;
        $changed(periph_reset) |-> $past(s_axi_bvalid) || system_reset || $past(system_reset);
    endproperty
    property p_urgent_pin;
        (urgent_pin_enable && urgent_interrupt && !system_reset && !core_reset)[*4]
            |-> ##[0:4] urgent_irq;
    endproperty
    property p_bor_irq;
        $rose(brownout_irq) |-> !system_reset;
    endproperty

    a_boot_after_por: assert property (p_boot_after_por) else $error("no boot fetch after reset");
    a_boot_core_free: assert property (p_boot_core_free) else $error("core held after fetch");
    a_core_drop_fetch: assert property (p_core_drop_fetch) else $error("core freed, no fetch");
    a_flash_bor: assert property (p_flash_bor) else $error("no reset on brown-out in flash op");
    a_core_only: assert property (p_core_only) else $error("core reset moved peripherals");
    a_periph_src: assert property (p_periph_src) else $error("peripheral reset moved alone");
    a_urgent_pin: assert property (p_urgent_pin) else $error("urgent pin ignored");
    a_bor_irq: assert property (p_bor_irq) else $error("brown-out irq with reset");

    c_boot: cover property (boot_fetch_start);
    c_wdog: cover property ($rose(wdog_irq));
    c_urgent: cover property ($rose(urgent_irq));
    c_bor: cover property ($rose(brownout_irq));
endmodule // rsc_reset_source_control_checker

bind rsc_reset_source_control rsc_reset_source_control_checker #(.PERIPH_W(PERIPH_W))
    rsc_reset_source_control_checker_i (.clock, .rstn, .s_axi_bvalid, .brownout_detect,
    .flash_busy, .urgent_interrupt, .urgent_pin_enable, .system_reset, .core_reset,
    .boot_fetch_start, .periph_reset, .brownout_irq, .wdog_irq, .urgent_irq);

// File: rsc_reset_source_control_tb_top.sv
// Self-checking bench for the reset source control block
module rsc_reset_source_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} rsc_row_t;
    logic clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic brownout_detect, flash_busy, ext_reset_n, urgent_interrupt, urgent_pin_enable;
    logic osc_fault;
    logic osc_wdog_tick = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire system_reset, core_reset, boot_fetch_start, brownout_irq, wdog_irq, urgent_irq;
    wire [95:0] periph_reset;
    wire [5:0] outs = {brownout_irq, urgent_irq, wdog_irq, core_reset, system_reset, boot_fetch_start};
    int n_fail = 0;
    int comparisons = 0;
    int i;
    // Plain register rows; last ones leave controls off
    rsc_row_t rows [8] = '{'{8'h08, 32'h0000_0005, 32'h0000_0005, 2'b00},
        '{8'h0C, 32'h8000_0001, 32'h8000_0001, 2'b00}, '{8'h10, 32'h0000_0100, 32'h0000_0100, 2'b00},
        '{8'h24, 32'h0000_0001, 32'h0000_0001, 2'b00}, '{8'h24, 32'h0000_0000, 32'h0000_0000, 2'b00},
        '{8'h3C, 32'h1234_5678, 32'h0000_0000, 2'b10}, '{8'h00, 32'h0000_0002, 32'h0000_0002, 2'b00},
        '{8'h00, 32'h0000_0000, 32'h0000_0000, 2'b00}};

    // Short hold count keeps the brown-out condition test brief
    rsc_reset_source_control #(.PERIPH_W(32), .BOR_HOLD(40)) rsc_reset_source_control_i (
        .clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .brownout_detect, .flash_busy, .ext_reset_n, .urgent_interrupt, .urgent_pin_enable,
        .osc_fault, .osc_wdog_tick, .system_reset, .core_reset, .boot_fetch_start, .periph_reset,
        .brownout_irq, .wdog_irq, .urgent_irq);

    // ****************************************************************
    // Clocks and helpers
    // ****************************************************************
    // System clock, 10 ns period
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Oscillator tick for the second watchdog, toggling on every rising clock edge
    always @(posedge clock) osc_wdog_tick <= ~osc_wdog_tick;

    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic hang();
        $display("BAD t=%0t wait ran out", $time);
        n_fail++;
        close_out();
    endtask
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic tdone(input string s);
        $display("test %s done at %0t", s, $time);
    endtask
    // One write: address and data held until each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        int n;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 100) hang();
        chk(s_axi_bresp, er);
    endtask
    // One read, masked compare of the data
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er = 2'b00);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clock);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 100) hang();
        chk(s_axi_rdata & m, e);
        chk(s_axi_rresp, er);
    endtask
    task automatic wait_hi(input int w);
        int n;
        for (n = 0; n < 400 && outs[w] !== 1'b1; n++) @(posedge clock);
        if (n == 400) hang();
    endtask
    task automatic por();
        rstn <= 1'b0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        wait_hi(0);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {brownout_detect, flash_busy, urgent_interrupt, urgent_pin_enable, osc_fault} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        ext_reset_n = 1'b1;
        por();
        rdc(8'h28, 32'hFFFF_FFFF, 32'h0000_0002);
        tdone("power on");
        brownout_detect <= 1'b1;
        repeat (6) @(posedge clock);
        brownout_detect <= 1'b0;
        wait_hi(5);
        chk(system_reset, 1'b0);
        rdc(8'h30, 32'h0000_0002, 32'h0000_0002);
        repeat (60) @(posedge clock);
        rdc(8'h30, 32'h0000_0002, 32'h0000_0000);
        wr(8'h30, 32'h0000_0001);
        repeat (2) @(posedge clock);
        chk(brownout_irq, 1'b0);
        tdone("brown-out interrupt");
        for (i = 0; i < 8; i++)
        begin
            wr(rows[i].a, rows[i].d, rows[i].r);
            rdc(rows[i].a, 32'hFFFF_FFFF, rows[i].e, rows[i].r);
        end
        chk(periph_reset, {32'h0000_0100, 32'h8000_0001, 32'h0000_0005});
        tdone("register rows");
        // Core-only reset keeps peripheral controls
        wr(8'h04, 32'h0000_0001);
        wait_hi(2);
        chk(system_reset, 1'b0);
        wait_hi(0);
        chk(periph_reset, {32'h0000_0100, 32'h8000_0001, 32'h0000_0005});
        wr(8'h08, 32'h0000_0000);
        repeat (2) @(posedge clock);
        chk(periph_reset[31:0], 32'h0000_0000);
        tdone("core reset");
        // Reset-selected brown-out held while supply stays low
        wr(8'h00, 32'h0000_0002);
        brownout_detect <= 1'b1;
        wait_hi(1);
        repeat (80) @(posedge clock);
        chk(system_reset, 1'b1);
        brownout_detect <= 1'b0;
        wait_hi(0);
        rdc(8'h28, 32'h0000_0004, 32'h0000_0004);
        wr(8'h00, 32'h0000_0000);
        repeat (60) @(posedge clock);
        flash_busy <= 1'b1;
        brownout_detect <= 1'b1;
        wait_hi(1);
        {flash_busy, brownout_detect} <= 2'b00;
        wait_hi(0);
        tdone("brown-out reset");
        wr(8'h04, 32'h0000_0004);
        wait_hi(1);
        wait_hi(0);
        rdc(8'h28, 32'h0000_0010, 32'h0000_0010);
        tdone("system request");
        wr(8'h14, 32'h0000_000A);
        wr(8'h1C, 32'h0000_0001);
        wr(8'h18, 32'h0000_0003);
        wait_hi(3);
        chk(system_reset, 1'b0);
        wait_hi(1);
        wait_hi(0);
        rdc(8'h28, 32'h0000_0008, 32'h0000_0008);
        tdone("watchdog");
        // Oscillator fault ignored until checking is on
        osc_fault <= 1'b1;
        repeat (20) @(posedge clock);
        chk(system_reset, 1'b0);
        osc_fault <= 1'b0;
        wr(8'h24, 32'h0000_0001);
        osc_fault <= 1'b1;
        wait_hi(1);
        osc_fault <= 1'b0;
        wait_hi(4);
        rdc(8'h28, 32'h0001_0000, 32'h0001_0000);
        tdone("oscillator fail");
        ext_reset_n <= 1'b0;
        repeat (10) @(posedge clock);
        ext_reset_n <= 1'b1;
        wait_hi(0);
        rdc(8'h28, 32'hFFFF_FFFF, 32'h0000_0001);
        tdone("external reset");
        // Pin needs its alternate function enabled
        por();
        urgent_interrupt <= 1'b1;
        repeat (10) @(posedge clock);
        chk(urgent_irq, 1'b0);
        urgent_pin_enable <= 1'b1;
        wait_hi(4);
        {urgent_interrupt, urgent_pin_enable} <= 2'b00;
        por();
        wr(8'h2C, 32'h8000_0000);
        wait_hi(4);
        tdone("urgent interrupt");
        close_out();
    end
endmodule // rsc_reset_source_control_tb_top
